// ===== rtl/ebrw_pkg.sv
// ebrw_pkg: shared types and constants of the ready-controlled bus cycle block
package ebrw_pkg;
	localparam int ADDR_W = 24;
	localparam int DATA_W = 16;
	localparam int WAIT_W = 5;
	localparam logic [WAIT_W-1:0] WAITS_RESET = 5'h00;
	localparam logic [ADDR_W-1:0] ADDR_RESET = 24'h000000;
	localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
	localparam int SYNC_STAGES = 2;

	typedef struct packed
	{
		logic write;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} ebrw_req_type;

	typedef struct packed
	{
		logic ready_high;
		logic ready_async;
		logic [WAIT_W-1:0] access_waits;
	} ebrw_cfg_type;

	typedef enum logic [1:0]
	{
		EBRW_IDLE,
		EBRW_ACCESS,
		EBRW_READY_WAIT
	} ebrw_state_type;
endpackage

// ===== rtl/ebrw_sync.sv
// ebrw_sync: two-flop level synchroniser
`timescale 1ns/10ps
module ebrw_sync
#(
	parameter int STAGES = ebrw_pkg::SYNC_STAGES
)
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic d_i,
	output logic q_o
);
	logic [STAGES-1:0] chain_q;
	logic [STAGES-1:0] chain_d;

	// one flop alone would pass metastable values on
	if (STAGES < 2)
	begin : g_stage_check
		$error("ebrw_sync needs at least two stages");
	end

	always_comb
	begin
		chain_d = {chain_q[STAGES-2:0], d_i};
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			chain_q <= '0;
		end
		else
		begin
			chain_q <= chain_d;
		end
	end

	assign q_o = chain_q[STAGES-1];
endmodule // ebrw_sync

// ===== rtl/ebrw_ctrl.sv
// ebrw_ctrl: external bus cycle engine with ready-controlled waitstates
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - ready active level is selectable
// - sync mode samples ready without synchroniser
// - async mode adds a waitstate for synchronising
// - inactive ready inserts waitstate, sample again
// - active ready ends the running cycle
// - async sample point lies two bus clocks later than sync
// - access waitstates finish before ready counts
// - read data latched as strobe rises
module ebrw_ctrl
(
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic bus_clk_i,
	input wire logic req_valid_i,
	input wire ebrw_pkg::ebrw_req_type req_i,
	input wire ebrw_pkg::ebrw_cfg_type cfg_i,
	output logic busy_o,
	output logic done_o,
	output logic [ebrw_pkg::DATA_W-1:0] rdata_o,
	input wire logic ready_i,
	input wire logic [ebrw_pkg::DATA_W-1:0] bus_rdata_i,
	output logic reference_clock_output_o,
	output logic rd_n_o,
	output logic wr_n_o,
	output logic [ebrw_pkg::ADDR_W-1:0] addr_o,
	output logic [ebrw_pkg::DATA_W-1:0] wdata_o,
	output logic data_oe_o
);
	////////////////////////////////////////////////////////////////////////////////
	// system side: hold request, toggle handshake
	ebrw_pkg::ebrw_req_type req_q;
	ebrw_pkg::ebrw_req_type req_d;
	ebrw_pkg::ebrw_cfg_type cfg_q;
	ebrw_pkg::ebrw_cfg_type cfg_d;
	logic go_tgl_q;
	logic go_tgl_d;
	logic busy_d;
	logic done_d;
	logic [ebrw_pkg::DATA_W-1:0] rdata_d;
	logic fin_tgl_sys;
	logic fin_seen_q;
	logic fin_seen_d;
	logic fin_tgl_q;
	logic [ebrw_pkg::DATA_W-1:0] lat_rdata_q;

	ebrw_sync u_fin_sync
	(
		.clk_i(sys_clk_i),
		.rst_i(rst_i),
		.d_i(fin_tgl_q),
		.q_o(fin_tgl_sys)
	);

	always_comb
	begin
		req_d = req_q;
		cfg_d = cfg_q;
		go_tgl_d = go_tgl_q;
		busy_d = busy_o;
		done_d = 1'b0;
		rdata_d = rdata_o;
		fin_seen_d = fin_tgl_sys;
		if (!busy_o && req_valid_i)
		begin
			req_d = req_i;
			cfg_d = cfg_i;
			go_tgl_d = ~go_tgl_q;
			busy_d = 1'b1;
		end
		if (busy_o && (fin_tgl_sys != fin_seen_q))
		begin
			busy_d = 1'b0;
			done_d = 1'b1;
			rdata_d = lat_rdata_q;
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			req_q <= '0;
			cfg_q <= '0;
			go_tgl_q <= 1'b0;
			busy_o <= 1'b0;
			done_o <= 1'b0;
			rdata_o <= ebrw_pkg::DATA_RESET;
			fin_seen_q <= 1'b0;
		end
		else
		begin
			req_q <= req_d;
			cfg_q <= cfg_d;
			go_tgl_q <= go_tgl_d;
			busy_o <= busy_d;
			done_o <= done_d;
			rdata_o <= rdata_d;
			fin_seen_q <= fin_seen_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// bus side: reference clock divider, ready sampling, cycle engine
	logic go_tgl_bus;
	logic go_seen_q;
	logic go_seen_d;
	logic phase_d;
	logic ready_pin_q;
	logic ready_async;
	logic ready_sample;
	logic ready_active;
	logic step;
	ebrw_pkg::ebrw_state_type state_q;
	ebrw_pkg::ebrw_state_type state_d;
	logic [ebrw_pkg::WAIT_W-1:0] cnt_q;
	logic [ebrw_pkg::WAIT_W-1:0] cnt_d;
	logic extra_q;
	logic extra_d;
	logic fin_tgl_d;
	logic [ebrw_pkg::DATA_W-1:0] lat_rdata_d;
	logic rd_n_d;
	logic wr_n_d;
	logic [ebrw_pkg::ADDR_W-1:0] addr_d;
	logic [ebrw_pkg::DATA_W-1:0] wdata_d;
	logic data_oe_d;

	ebrw_sync u_go_sync
	(
		.clk_i(bus_clk_i),
		.rst_i(rst_i),
		.d_i(go_tgl_q),
		.q_o(go_tgl_bus)
	);

	ebrw_sync u_rdy_sync
	(
		.clk_i(bus_clk_i),
		.rst_i(rst_i),
		.d_i(ready_i),
		.q_o(ready_async)
	);

	always_comb
	begin
		phase_d = ~reference_clock_output_o;
		step = reference_clock_output_o;
		ready_sample = cfg_q.ready_async ? ready_async : ready_pin_q;
		ready_active = (ready_sample == cfg_q.ready_high);
		go_seen_d = go_seen_q;
		state_d = state_q;
		cnt_d = cnt_q;
		extra_d = extra_q;
		fin_tgl_d = fin_tgl_q;
		lat_rdata_d = lat_rdata_q;
		rd_n_d = rd_n_o;
		wr_n_d = wr_n_o;
		addr_d = addr_o;
		wdata_d = wdata_o;
		data_oe_d = data_oe_o;
		if (step)
		begin
			case (state_q)
				ebrw_pkg::EBRW_IDLE:
				begin
					if (go_tgl_bus != go_seen_q)
					begin
						go_seen_d = go_tgl_bus;
						addr_d = req_q.addr;
						wdata_d = req_q.wdata;
						data_oe_d = req_q.write;
						rd_n_d = req_q.write;
						wr_n_d = ~req_q.write;
						cnt_d = cfg_q.access_waits;
						extra_d = cfg_q.ready_async;
						state_d = ebrw_pkg::EBRW_ACCESS;
					end
				end
				ebrw_pkg::EBRW_ACCESS:
				begin
					if (cnt_q != ebrw_pkg::WAITS_RESET)
						cnt_d = cnt_q - 5'h01;
					else
						state_d = ebrw_pkg::EBRW_READY_WAIT;
				end
				ebrw_pkg::EBRW_READY_WAIT:
				begin
					if (extra_q)
						extra_d = 1'b0;
					else if (ready_active)
					begin
						lat_rdata_d = rd_n_o ? lat_rdata_q : bus_rdata_i;
						rd_n_d = 1'b1;
						wr_n_d = 1'b1;
						data_oe_d = 1'b0;
						addr_d = ebrw_pkg::ADDR_RESET;
						fin_tgl_d = ~fin_tgl_q;
						state_d = ebrw_pkg::EBRW_IDLE;
					end
					else
						state_d = ebrw_pkg::EBRW_READY_WAIT;
				end
				default:
					state_d = ebrw_pkg::EBRW_IDLE;
			endcase
		end
	end

	always_ff @(posedge bus_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			reference_clock_output_o <= 1'b0;
			ready_pin_q <= 1'b0;
			go_seen_q <= 1'b0;
			state_q <= ebrw_pkg::EBRW_IDLE;
			cnt_q <= ebrw_pkg::WAITS_RESET;
			extra_q <= 1'b0;
			fin_tgl_q <= 1'b0;
			lat_rdata_q <= ebrw_pkg::DATA_RESET;
			rd_n_o <= 1'b1;
			wr_n_o <= 1'b1;
			addr_o <= ebrw_pkg::ADDR_RESET;
			wdata_o <= ebrw_pkg::DATA_RESET;
			data_oe_o <= 1'b0;
		end
		else
		begin
			reference_clock_output_o <= phase_d;
			ready_pin_q <= ready_i;
			go_seen_q <= go_seen_d;
			state_q <= state_d;
			cnt_q <= cnt_d;
			extra_q <= extra_d;
			fin_tgl_q <= fin_tgl_d;
			lat_rdata_q <= lat_rdata_d;
			rd_n_o <= rd_n_d;
			wr_n_o <= wr_n_d;
			addr_o <= addr_d;
			wdata_o <= wdata_d;
			data_oe_o <= data_oe_d;
		end
	end
endmodule // ebrw_ctrl

// ===== tb/ebrw_mem.sv
// ebrw_mem: external circuit that answers with ready after a set delay
`timescale 1ns/10ps
module ebrw_mem
(
	input wire logic bus_clk_i,
	input wire logic rd_n_i,
	input wire logic wr_n_i,
	input wire logic hi_i,
	input wire logic [4:0] dly_i,
	input wire logic [15:0] addr_i,
	input wire logic [15:0] wd_i,
	output logic rdy_o,
	output logic [15:0] rd_o,
	output logic [15:0] wm_o
);
	int n = 0;
	initial rd_o = 16'h0000;
	always @(negedge bus_clk_i)
	begin
		n = (rd_n_i & wr_n_i) ? 0 : n + 1;
		rdy_o <= ~hi_i ^ (n > dly_i);
		rd_o <= rd_n_i ? ~rd_o : addr_i ^ 16'h5A5A;
		if (!wr_n_i)
			wm_o <= wd_i;
	end
endmodule // ebrw_mem

// ===== tb/ebrw_ctrl_props.sv
// ebrw_ctrl_props: checker on the bus cycle engine ports
`timescale 1ns/10ps
module ebrw_ctrl_props
(
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic bus_clk_i,
	input wire ebrw_pkg::ebrw_cfg_type cfg_i,
	input wire logic done_o,
	input wire logic reference_clock_output_o,
	input wire logic ready_i,
	input wire logic rd_n_o,
	input wire logic wr_n_o,
	input wire logic [ebrw_pkg::ADDR_W-1:0] addr_o,
	input wire logic data_oe_o
);
	logic [7:0] cnt_q;
	logic [7:0] cnt_d;
	logic idle;
	logic act;
	assign idle = rd_n_o & wr_n_o;
	assign act = ready_i == cfg_i.ready_high;
	always_comb cnt_d = idle ? 8'h00 : cnt_q + 8'h01;
	always_ff @(posedge bus_clk_i or posedge rst_i)
		cnt_q <= rst_i ? 8'h00 : cnt_d;
	////////////////////////////////////////
	a_done_ends: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		done_o |-> idle) else $error("done with strobe low");
	a_done_pulse: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		done_o |=> !done_o) else $error("done too long");
	a_wait_holds: assert property (@(posedge bus_clk_i) disable iff (rst_i)
		(!idle && !act && !cfg_i.ready_async)[*3] |=> !idle) else $error("no wait");
	a_access_min: assert property (@(posedge bus_clk_i) disable iff (rst_i)
		$rose(idle) |-> cnt_q >= 2 * cfg_i.access_waits + 4) else $error("short access");
	a_async_extra: assert property (@(posedge bus_clk_i) disable iff (rst_i)
		$rose(idle) && cfg_i.ready_async |-> cnt_q >= 2 * cfg_i.access_waits + 6)
		else $error("no sync wait");
	a_oe_write: assert property (@(posedge bus_clk_i) disable iff (rst_i)
		data_oe_o == !wr_n_o) else $error("oe mismatch");
	a_strobe_excl: assert property (@(posedge bus_clk_i) disable iff (rst_i)
		rd_n_o | wr_n_o) else $error("both strobes low");
	a_addr_clear: assert property (@(posedge bus_clk_i) disable iff (rst_i)
		$rose(idle) |-> addr_o == 24'h000000 && !data_oe_o) else $error("bus not released");
	a_ref_toggle: assert property (@(posedge bus_clk_i) disable iff (rst_i)
		!$past(rst_i) |-> reference_clock_output_o != $past(reference_clock_output_o))
		else $error("reference clock stuck");
	a_strobe_step: assert property (@(posedge bus_clk_i) disable iff (rst_i)
		$changed(rd_n_o) || $changed(wr_n_o) |-> $past(reference_clock_output_o))
		else $error("strobe moved off step");
endmodule // ebrw_ctrl_props
bind ebrw_ctrl ebrw_ctrl_props ebrw_ctrl_props_inst (.*);

// ===== tb/test_ext_bus_ready_waitstate_ctrl.sv
// test_ext_bus_ready_waitstate_ctrl: table driven bench for the bus cycle engine
`timescale 1ns/10ps
module test_ext_bus_ready_waitstate_ctrl;
	typedef struct packed
	{
		logic w;
		logic a;
		logic h;
		logic [4:0] aw;
		logic [4:0] dl;
		logic [15:0] ad;
		logic [15:0] wd;
		logic [7:0] ek;
	} ebrw_row_type;
	ebrw_row_type rows [5] = '{
		{1'h0, 1'h0, 1'h1, 5'h00, 5'h00, 16'h1234, 16'h0000, 8'h04},
		{1'h0, 1'h1, 1'h1, 5'h00, 5'h00, 16'h4321, 16'h0000, 8'h06},
		{1'h1, 1'h0, 1'h0, 5'h03, 5'h10, 16'h00F0, 16'hBEEF, 8'h12},
		{1'h0, 1'h1, 1'h0, 5'h1F, 5'h02, 16'hFFFF, 16'h0000, 8'h44},
		{1'h1, 1'h1, 1'h1, 5'h01, 5'h09, 16'h8001, 16'hC0DE, 8'h0C}};
	ebrw_row_type r;
	logic sys_clk_i = 0, bus_clk_i = 0, rst_i = 1, req_valid_i = 0;
	ebrw_pkg::ebrw_req_type req_i = '0;
	ebrw_pkg::ebrw_cfg_type cfg_i = '0;
	logic busy_o, done_o, ready_i, reference_clock_output_o, rd_n_o, wr_n_o, data_oe_o;
	logic [15:0] rdata_o, bus_rdata_i, wdata_o, wm;
	logic [23:0] addr_o;
	int n_mismatch = 0, tests_run = 0, k = 0, j;
	int kk [5];
	initial forever #50 sys_clk_i = ~sys_clk_i;
	initial #3 forever #7.5 bus_clk_i = ~bus_clk_i;
	always @(posedge bus_clk_i) k = (rd_n_o & wr_n_o) ? k : k + 1;
	ebrw_ctrl ebrw_ctrl_inst (.sys_clk_i, .rst_i, .bus_clk_i, .req_valid_i, .req_i,
		.cfg_i, .busy_o, .done_o, .rdata_o, .ready_i, .bus_rdata_i,
		.reference_clock_output_o, .rd_n_o, .wr_n_o, .addr_o, .wdata_o, .data_oe_o);
	ebrw_mem ebrw_mem_inst (.bus_clk_i, .rd_n_i(rd_n_o), .wr_n_i(wr_n_o),
		.hi_i(cfg_i.ready_high), .dly_i(r.dl), .addr_i(addr_o[15:0]), .wd_i(wdata_o),
		.rdy_o(ready_i), .rd_o(bus_rdata_i), .wm_o(wm));
	////////////////////////////////////////
	task automatic check(input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e)
		begin
			n_mismatch++;
			$display("[ERR] %0t %h %h", $time, s, e);
		end
	endtask
	task final_report;
		$display("mismatches %0d tests %0d", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic run_row(input ebrw_row_type row);
		r = row;
		cfg_i = '{row.h, row.a, row.aw};
		req_i = '{row.w, {8'h00, row.ad}, row.wd};
		k = 0;
		req_valid_i = 1;
		@(negedge sys_clk_i);
		req_valid_i = 0;
		check(busy_o, 1);
		for (j = 0; j < 400 && done_o !== 1'b1; j++)
			@(negedge sys_clk_i);
		if (j == 400)
			check(0, 1);
		else
		begin
			check(busy_o, 0);
			check(k >= row.dl + 1, 1);
			check(k, row.ek);
			check(row.w ? wm : rdata_o, row.w ? row.wd : row.ad ^ 16'h5A5A);
		end
		@(negedge sys_clk_i);
	endtask
	////////////////////////////////////////
	initial
	begin
		r = rows[0];
		repeat (16) @(negedge sys_clk_i);
		rst_i = 0;
		check({rd_n_o, wr_n_o, busy_o, addr_o}, 27'h6000000);
		foreach (rows[i])
		begin
			run_row(rows[i]);
			kk[i] = k;
		end
		check(kk[1] > kk[0], 1);
		// reset in the middle of a long cycle, then a normal cycle again
		r = rows[3];
		cfg_i = '{r.h, r.a, r.aw};
		req_i = '{r.w, {8'h00, r.ad}, r.wd};
		req_valid_i = 1;
		@(negedge sys_clk_i);
		req_valid_i = 0;
		repeat (2) @(negedge sys_clk_i);
		check(rd_n_o, 0);
		rst_i = 1;
		@(negedge sys_clk_i);
		check({rd_n_o, wr_n_o, busy_o, addr_o}, 27'h6000000);
		@(negedge sys_clk_i);
		rst_i = 0;
		run_row(rows[0]);
		final_report;
	end
endmodule // test_ext_bus_ready_waitstate_ctrl
